//--- pkg/crp_map.svh
`ifndef CRP_MAP_SVH
`define CRP_MAP_SVH
`define CRP_OFS_CLOCK_SETUP 16'h4000
`define CRP_OFS_PDM_TONE 16'h4008
`define CRP_OFS_BIAS_TONE_EN 16'h4010
`define CRP_OFS_RECORD_CTRL 16'h4019
`define CRP_OFS_RECORD_LVOL 16'h401a
`define CRP_OFS_RECORD_RVOL 16'h401b
`define CRP_OFS_MONO_MIX 16'h401f
`define CRP_OFS_SPEAKER 16'h4027
`define CRP_OFS_PLAY_CTRL 16'h402a
`define CRP_OFS_PLAY_LVOL 16'h402b
`define CRP_OFS_PLAY_RVOL 16'h402c
`define CRP_OFS_STATUS 16'h4030
`define CRP_RST_REG 8'h00
// pdm_mic_and_tone_setup fields
`define CRP_PDM_EN1_BIT 0
`define CRP_PDM_EN2_BIT 1
`define CRP_TONE_MUTE_BIT 2
`define CRP_TONE_GAIN_LSB 3
// bias_and_tone_enable fields
`define CRP_TONE_EN_BIT 0
// record_path_control fields
`define CRP_REC_OSR_BIT 0
`define CRP_REC_EN_BIT 1
`define CRP_REC_HPF_BIT 5
// playback_path_control fields
`define CRP_PLAY_OSR_BIT 0
`define CRP_PLAY_EN_BIT 1
`define CRP_PLAY_DEEMPH_BIT 2
// mono_mixer_setup fields
`define CRP_MIX_LEFT_BIT 0
`define CRP_MIX_RIGHT_BIT 1
`define CRP_MIX_TONE_BIT 2
// speaker_output_setup fields
`define CRP_SPK_EN_BIT 0
`define CRP_SPK_MUTE_BIT 1
`define CRP_SPK_GAIN_LSB 2
// clock_setup fields
`define CRP_MCK_DIV_LSB 0
// precharge time
`define CRP_PRECHARGE_MS 8
`define CRP_CLK_MHZ 200
`define CRP_PRECHARGE_CYC (`CRP_PRECHARGE_MS * 1000 * `CRP_CLK_MHZ)
`define CRP_GATE_CYC 4
`endif

//--- pkg/crp_pkg.sv
package crp_pkg;
  typedef enum logic [1:0] {
    CRP_SRC_NONE,
    CRP_SRC_ANALOG,
    CRP_SRC_PDM
  } crp_src_t;
  typedef enum logic [2:0] {
    CRP_SPK_OFF,
    CRP_SPK_CHARGE,
    CRP_SPK_GATE,
    CRP_SPK_ON,
    CRP_SPK_MUTING,
    CRP_SPK_UNGATE
  } crp_spk_state_t;
endpackage

//--- core/crp_skid_buf.sv
`timescale 1ns/1ps
// two-entry buffer; ready stays high while one slot is free, and a word offered while both slots are full is not taken
module crp_skid_buf #(
  parameter int WIDTH = 48
) (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  logic [WIDTH-1:0] slot0;
  logic [WIDTH-1:0] slot1;
  logic [1:0] count;
  logic push;
  logic pop;

  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      count <= 2'h0;
    end else begin
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      slot0 <= '0;
      slot1 <= '0;
    end else begin
      if (pop) begin
        slot0 <= (count == 2'h2) ? slot1 : in_data_in;
      end else if (push && count == 2'h0) begin
        slot0 <= in_data_in;
      end
      if (push && ((count == 2'h1 && !pop) || (count == 2'h2))) begin
        slot1 <= in_data_in;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      in_ready_out <= 1'b1;
      out_valid_out <= 1'b0;
    end else begin
      in_ready_out <= (count + {1'b0, push} - {1'b0, pop}) != 2'h2;
      out_valid_out <= (count + {1'b0, push} - {1'b0, pop}) != 2'h0;
    end
  end

  assign out_data_out = slot0;
endmodule // crp_skid_buf

//--- core/crp_path_ctrl.sv
`timescale 1ns/1ps
`include "crp_map.svh"
module crp_path_ctrl
  import crp_pkg::*;
#(
  parameter int PRECHARGE_CYC = `CRP_PRECHARGE_CYC,
  parameter int SAMPLE_W = 24
) (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic sample_tick_in,
  input wire logic [SAMPLE_W-1:0] rec_adc_left_in,
  input wire logic [SAMPLE_W-1:0] rec_adc_right_in,
  input wire logic pdm_mic_data_1,
  input wire logic pdm_mic_data_2,
  output logic mic_clock_out,
  output logic rec_valid_out,
  input wire logic rec_ready_in,
  output logic [SAMPLE_W-1:0] rec_left_out,
  output logic [SAMPLE_W-1:0] rec_right_out,
  output logic pdm_bits_out,
  output logic rec_analog_en_out,
  output logic rec_osr128_out,
  output logic rec_hpf_en_out,
  output logic [7:0] rec_left_atten_out,
  output logic [7:0] rec_right_atten_out,
  output logic play_en_out,
  output logic play_osr128_out,
  output logic play_deemph_en_out,
  output logic [7:0] play_left_atten_out,
  output logic [7:0] play_right_atten_out,
  output logic line_left_dac_out,
  output logic line_right_dac_out,
  output logic line_tone_out,
  output logic mono_left_out,
  output logic mono_right_out,
  output logic mono_tone_out,
  output logic [4:0] tone_gain_out,
  output logic tone_mute_out,
  output logic [1:0] spk_gain_out,
  output logic spk_precharge_out,
  output logic spk_gate_out,
  output logic spk_mute_release_out
);
  logic [7:0] clock_setup;
  logic [7:0] pdm_mic_and_tone_setup;
  logic [7:0] bias_and_tone_enable;
  logic [7:0] mono_mixer_setup;
  logic [7:0] record_path_control;
  logic [7:0] record_left_volume;
  logic [7:0] record_right_volume;
  logic [7:0] speaker_output_setup;
  logic [7:0] playback_path_control;
  logic [7:0] playback_left_volume;
  logic [7:0] playback_right_volume;
  crp_src_t rec_src;
  crp_spk_state_t spk_state;
  logic [31:0] spk_count;
  logic [7:0] mck_count;
  logic [SAMPLE_W-1:0] pdm_acc_l;
  logic [SAMPLE_W-1:0] pdm_acc_r;
  logic mck_rise;
  logic spk_on_req;
  logic buf_valid;
  logic [2*SAMPLE_W-1:0] buf_out;
  logic [SAMPLE_W-1:0] next_left;
  logic [SAMPLE_W-1:0] next_right;
  logic pdm_sel;
  logic pdm_any;

  ////////////////////////////////////////////////////////////////////////////
  // register port
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      clock_setup <= `CRP_RST_REG;
      pdm_mic_and_tone_setup <= `CRP_RST_REG;
      bias_and_tone_enable <= `CRP_RST_REG;
      mono_mixer_setup <= `CRP_RST_REG;
      record_path_control <= `CRP_RST_REG;
      record_left_volume <= `CRP_RST_REG;
      record_right_volume <= `CRP_RST_REG;
      speaker_output_setup <= `CRP_RST_REG;
      playback_path_control <= `CRP_RST_REG;
      playback_left_volume <= `CRP_RST_REG;
      playback_right_volume <= `CRP_RST_REG;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `CRP_OFS_CLOCK_SETUP: clock_setup <= reg_wdata_in;
        `CRP_OFS_PDM_TONE: pdm_mic_and_tone_setup <= reg_wdata_in;
        `CRP_OFS_BIAS_TONE_EN: bias_and_tone_enable <= reg_wdata_in;
        `CRP_OFS_MONO_MIX: mono_mixer_setup <= reg_wdata_in;
        `CRP_OFS_RECORD_CTRL: record_path_control <= reg_wdata_in;
        `CRP_OFS_RECORD_LVOL: record_left_volume <= reg_wdata_in;
        `CRP_OFS_RECORD_RVOL: record_right_volume <= reg_wdata_in;
        `CRP_OFS_SPEAKER: speaker_output_setup <= reg_wdata_in;
        `CRP_OFS_PLAY_CTRL: playback_path_control <= reg_wdata_in;
        `CRP_OFS_PLAY_LVOL: playback_left_volume <= reg_wdata_in;
        `CRP_OFS_PLAY_RVOL: playback_right_volume <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `CRP_OFS_CLOCK_SETUP: reg_rdata_out <= clock_setup;
        `CRP_OFS_PDM_TONE: reg_rdata_out <= pdm_mic_and_tone_setup;
        `CRP_OFS_BIAS_TONE_EN: reg_rdata_out <= bias_and_tone_enable;
        `CRP_OFS_MONO_MIX: reg_rdata_out <= mono_mixer_setup;
        `CRP_OFS_RECORD_CTRL: reg_rdata_out <= record_path_control;
        `CRP_OFS_RECORD_LVOL: reg_rdata_out <= record_left_volume;
        `CRP_OFS_RECORD_RVOL: reg_rdata_out <= record_right_volume;
        `CRP_OFS_SPEAKER: reg_rdata_out <= speaker_output_setup;
        `CRP_OFS_PLAY_CTRL: reg_rdata_out <= playback_path_control;
        `CRP_OFS_PLAY_LVOL: reg_rdata_out <= playback_left_volume;
        `CRP_OFS_PLAY_RVOL: reg_rdata_out <= playback_right_volume;
        `CRP_OFS_STATUS: reg_rdata_out <= {3'h0, spk_state, rec_src};
        default: reg_rdata_out <= 8'h00;
      endcase
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // settings applied at sample boundary
  assign pdm_any = pdm_mic_and_tone_setup[`CRP_PDM_EN1_BIT]
                || pdm_mic_and_tone_setup[`CRP_PDM_EN2_BIT];

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rec_src <= CRP_SRC_NONE;
      rec_analog_en_out <= 1'b0;
      rec_osr128_out <= 1'b0;
      rec_hpf_en_out <= 1'b0;
      rec_left_atten_out <= 8'h00;
      rec_right_atten_out <= 8'h00;
      play_en_out <= 1'b0;
      play_osr128_out <= 1'b0;
      play_deemph_en_out <= 1'b0;
      play_left_atten_out <= 8'h00;
      play_right_atten_out <= 8'h00;
    end else if (sample_tick_in) begin
      // pdm wins so decimation never sees both sources
      if (pdm_any) begin
        rec_src <= CRP_SRC_PDM;
      end else if (record_path_control[`CRP_REC_EN_BIT]) begin
        rec_src <= CRP_SRC_ANALOG;
      end else begin
        rec_src <= CRP_SRC_NONE;
      end
      rec_analog_en_out <= !pdm_any && record_path_control[`CRP_REC_EN_BIT];
      rec_osr128_out <= record_path_control[`CRP_REC_OSR_BIT];
      rec_hpf_en_out <= record_path_control[`CRP_REC_HPF_BIT];
      rec_left_atten_out <= record_left_volume;
      rec_right_atten_out <= record_right_volume;
      play_en_out <= playback_path_control[`CRP_PLAY_EN_BIT];
      play_osr128_out <= playback_path_control[`CRP_PLAY_OSR_BIT];
      play_deemph_en_out <= playback_path_control[`CRP_PLAY_DEEMPH_BIT];
      play_left_atten_out <= playback_left_volume;
      play_right_atten_out <= playback_right_volume;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output mixers; tone only when its input is enabled
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      line_left_dac_out <= 1'b0;
      line_right_dac_out <= 1'b0;
      line_tone_out <= 1'b0;
      mono_left_out <= 1'b0;
      mono_right_out <= 1'b0;
      mono_tone_out <= 1'b0;
      tone_gain_out <= 5'h00;
      tone_mute_out <= 1'b1;
    end else begin
      line_left_dac_out <= play_en_out;
      line_right_dac_out <= play_en_out;
      line_tone_out <= bias_and_tone_enable[`CRP_TONE_EN_BIT];
      mono_left_out <= mono_mixer_setup[`CRP_MIX_LEFT_BIT];
      mono_right_out <= mono_mixer_setup[`CRP_MIX_RIGHT_BIT];
      mono_tone_out <= mono_mixer_setup[`CRP_MIX_TONE_BIT]
                    && bias_and_tone_enable[`CRP_TONE_EN_BIT];
      tone_gain_out <= pdm_mic_and_tone_setup[`CRP_TONE_GAIN_LSB +: 5];
      tone_mute_out <= pdm_mic_and_tone_setup[`CRP_TONE_MUTE_BIT]
                    || !bias_and_tone_enable[`CRP_TONE_EN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mic clock: divider (setting + 1) half periods
  assign mck_rise = (mck_count == clock_setup) && !mic_clock_out;

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mck_count <= 8'h00;
      mic_clock_out <= 1'b0;
    end else if (!pdm_any) begin
      mck_count <= 8'h00;
      mic_clock_out <= 1'b0;
    end else if (mck_count >= clock_setup) begin
      mck_count <= 8'h00;
      mic_clock_out <= !mic_clock_out;
    end else begin
      mck_count <= mck_count + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pdm bits go straight to the decimator, converters bypassed
  assign pdm_sel = (rec_src == CRP_SRC_PDM);

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pdm_bits_out <= 1'b0;
      pdm_acc_l <= '0;
      pdm_acc_r <= '0;
    end else begin
      pdm_bits_out <= pdm_sel && (pdm_mic_data_1 || pdm_mic_data_2);
      if (sample_tick_in) begin
        pdm_acc_l <= '0;
        pdm_acc_r <= '0;
      end else if (pdm_sel && mck_rise) begin
        pdm_acc_l <= pdm_acc_l + SAMPLE_W'(pdm_mic_data_1);
        pdm_acc_r <= pdm_acc_r + SAMPLE_W'(pdm_mic_data_2);
      end
    end
  end

  always_comb begin
    next_left = '0;
    next_right = '0;
    if (pdm_sel) begin
      next_left = pdm_mic_and_tone_setup[`CRP_PDM_EN1_BIT] ? pdm_acc_l : '0;
      next_right = pdm_mic_and_tone_setup[`CRP_PDM_EN2_BIT] ? pdm_acc_r : '0;
    end else if (rec_src == CRP_SRC_ANALOG) begin
      next_left = rec_adc_left_in;
      next_right = rec_adc_right_in;
    end
  end

  crp_skid_buf #(
    .WIDTH(2 * SAMPLE_W)
  ) u_rec_buf (
    .mclk_in(mclk_in),
    .arst_n_in(arst_n_in),
    .in_valid_in(sample_tick_in && rec_src != CRP_SRC_NONE),
    .in_ready_out(),
    .in_data_in({next_left, next_right}),
    .out_valid_out(buf_valid),
    .out_ready_in(rec_ready_in),
    .out_data_out(buf_out)
  );

  // buffer flops drive the outputs, so valid, data and ready meet at one edge
  assign rec_valid_out = buf_valid;
  assign rec_left_out = buf_out[2*SAMPLE_W-1:SAMPLE_W];
  assign rec_right_out = buf_out[SAMPLE_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // speaker sequencer
  assign spk_on_req = speaker_output_setup[`CRP_SPK_EN_BIT];

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      spk_state <= CRP_SPK_OFF;
      spk_count <= 32'h0;
    end else begin
      spk_count <= spk_count + 32'h1;
      case (spk_state)
        CRP_SPK_OFF: begin
          spk_count <= 32'h0;
          if (spk_on_req) spk_state <= CRP_SPK_CHARGE;
        end
        CRP_SPK_CHARGE: begin
          if (!spk_on_req) begin
            spk_state <= CRP_SPK_OFF;
          end else if (spk_count == 32'(PRECHARGE_CYC - 1)) begin
            spk_state <= CRP_SPK_ON;
          end
        end
        CRP_SPK_ON: begin
          spk_count <= 32'h0;
          if (!spk_on_req) spk_state <= CRP_SPK_MUTING;
        end
        CRP_SPK_MUTING: begin
          if (spk_count == 32'(`CRP_GATE_CYC - 1)) begin
            spk_state <= CRP_SPK_UNGATE;
            spk_count <= 32'h0;
          end
        end
        CRP_SPK_UNGATE: begin
          if (spk_count == 32'(`CRP_GATE_CYC - 1)) spk_state <= CRP_SPK_OFF;
        end
        default: spk_state <= CRP_SPK_OFF;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      spk_precharge_out <= 1'b0;
      spk_gate_out <= 1'b0;
      spk_mute_release_out <= 1'b0;
      spk_gain_out <= 2'h0;
    end else begin
      spk_gain_out <= speaker_output_setup[`CRP_SPK_GAIN_LSB +: 2];
      // precharge held through ungating, so it is the last step undone
      spk_precharge_out <= spk_state != CRP_SPK_OFF;
      spk_gate_out <= spk_state == CRP_SPK_CHARGE || spk_state == CRP_SPK_ON
                   || spk_state == CRP_SPK_MUTING;
      spk_mute_release_out <= spk_state == CRP_SPK_ON
                           && !speaker_output_setup[`CRP_SPK_MUTE_BIT];
    end
  end

  a_mute_after_charge: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    $rose(spk_mute_release_out) |-> $past(spk_gate_out, 2))
    else $error("mute released without precharge");
  a_mute_before_ungate: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    $fell(spk_gate_out) |-> !spk_mute_release_out)
    else $error("gating undone while unmuted");
  a_off_no_output: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    !spk_precharge_out |-> !spk_mute_release_out)
    else $error("speaker unmuted while powered down");
  a_single_source: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    rec_src == CRP_SRC_PDM |=> !rec_analog_en_out || $past(sample_tick_in))
    else $error("both record sources active");
  a_hpf_boundary: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    $changed(rec_hpf_en_out) |-> $past(sample_tick_in))
    else $error("filter changed off boundary");
  a_atten_follow: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    sample_tick_in |=> play_left_atten_out == $past(playback_left_volume))
    else $error("playback attenuation not applied");
  a_rec_atten: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    sample_tick_in |=> rec_right_atten_out == $past(record_right_volume))
    else $error("record attenuation not applied");
  a_tone_gate: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
    !bias_and_tone_enable[`CRP_TONE_EN_BIT] |=> !mono_tone_out && tone_mute_out)
    else $error("tone mixed while disabled");
endmodule // crp_path_ctrl

//--- verification/crp_far_side.sv
`timescale 1ns/1ps
// microphones, record converters and the record sink on the far side
module crp_far_side (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic tick_in,
  input wire logic stall_in,
  input wire logic mic_clock_in,
  output logic [23:0] adc_left_out,
  output logic [23:0] adc_right_out,
  output logic pdm_1_out,
  output logic pdm_2_out,
  output logic ready_out
);
  logic [23:0] n;
  logic mck_seen;
  assign adc_left_out = 24'h100000 + n;
  assign adc_right_out = 24'h200000 + n;
  assign ready_out = !stall_in;
  // words move only after a tick, so each tick sees one stable pair
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) n <= 24'h0;
    else if (tick_in) n <= n + 24'h1;
  end
  // complementary streams: their or is always 1; they move only on a mic clock rise
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mck_seen <= 1'b0;
      pdm_1_out <= 1'b0;
    end else begin
      mck_seen <= mic_clock_in;
      if (mic_clock_in && !mck_seen) pdm_1_out <= !pdm_1_out;
    end
  end
  assign pdm_2_out = !pdm_1_out;
endmodule // crp_far_side

//--- verification/test_crp_path_ctrl.sv
`timescale 1ns/1ps
`include "crp_map.svh"
module test_crp_path_ctrl;
  import crp_pkg::*;
  localparam int PRE = 20;
  logic mclk_in = 0, arst_n_in = 0, reg_wr_in = 0, reg_rd_in = 0, sample_tick_in = 0, stall = 0;
  logic [15:0] reg_addr_in = 16'h0;
  logic [7:0] reg_wdata_in = 8'h0, reg_rdata_out, rec_left_atten_out, rec_right_atten_out;
  logic [7:0] play_left_atten_out, play_right_atten_out;
  logic [23:0] rec_adc_left_in, rec_adc_right_in, rec_left_out, rec_right_out;
  logic pdm_mic_data_1, pdm_mic_data_2, mic_clock_out, rec_valid_out, rec_ready_in, m0;
  logic pdm_bits_out, rec_analog_en_out, rec_osr128_out, rec_hpf_en_out, play_en_out;
  logic play_osr128_out, play_deemph_en_out, line_left_dac_out, line_right_dac_out;
  logic line_tone_out, mono_left_out, mono_right_out, mono_tone_out, tone_mute_out;
  logic spk_precharge_out, spk_gate_out, spk_mute_release_out;
  logic [4:0] tone_gain_out;
  logic [1:0] spk_gain_out;
  int fails = 0, check_count = 0, ticks = 0, t0, got, k;
  logic [15:0] regs [11] = '{`CRP_OFS_CLOCK_SETUP, `CRP_OFS_PDM_TONE, `CRP_OFS_BIAS_TONE_EN,
    `CRP_OFS_RECORD_CTRL, `CRP_OFS_RECORD_LVOL, `CRP_OFS_RECORD_RVOL, `CRP_OFS_MONO_MIX,
    `CRP_OFS_SPEAKER, `CRP_OFS_PLAY_CTRL, `CRP_OFS_PLAY_LVOL, `CRP_OFS_PLAY_RVOL};
  always #2.5 mclk_in = ~mclk_in;
  crp_path_ctrl #(.PRECHARGE_CYC(PRE)) uut (.mclk_in, .arst_n_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .sample_tick_in, .rec_adc_left_in,
    .rec_adc_right_in, .pdm_mic_data_1, .pdm_mic_data_2, .mic_clock_out, .rec_valid_out,
    .rec_ready_in, .rec_left_out, .rec_right_out, .pdm_bits_out, .rec_analog_en_out,
    .rec_osr128_out, .rec_hpf_en_out, .rec_left_atten_out, .rec_right_atten_out, .play_en_out,
    .play_osr128_out, .play_deemph_en_out, .play_left_atten_out, .play_right_atten_out,
    .line_left_dac_out, .line_right_dac_out, .line_tone_out, .mono_left_out, .mono_right_out,
    .mono_tone_out, .tone_gain_out, .tone_mute_out, .spk_gain_out, .spk_precharge_out,
    .spk_gate_out, .spk_mute_release_out);
  crp_far_side far (.mclk_in, .arst_n_in, .tick_in(sample_tick_in), .stall_in(stall),
    .mic_clock_in(mic_clock_out), .adc_left_out(rec_adc_left_in),
    .adc_right_out(rec_adc_right_in), .pdm_1_out(pdm_mic_data_1),
    .pdm_2_out(pdm_mic_data_2), .ready_out(rec_ready_in));
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge mclk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= v;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rdc(input string what, input logic [15:0] a, input logic [7:0] e);
    @(posedge mclk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    #1 chk(what, reg_rdata_out, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic tk;
    @(posedge mclk_in);
    sample_tick_in <= 1'b1;
    ticks++;
    @(posedge mclk_in);
    sample_tick_in <= 1'b0;
    cyc(3);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // whole run is under 400 cycles; allow fifty times that
  initial begin
    #100000;
    fails++;
    test_done;
  end
  ////////////////////////////////////////
  initial begin
    repeat (6) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    cyc(1);
    chk("tone mute at reset", tone_mute_out, 1);
    foreach (regs[i]) rdc("reset value", regs[i], 8'h00);
    wr(16'h4001, 8'hff);
    rdc("unmapped", 16'h4001, 8'h00);
    wr(`CRP_OFS_STATUS, 8'hff);
    rdc("status read only", `CRP_OFS_STATUS, 8'h00);
    foreach (regs[i]) wr(regs[i], {i[3:0], 4'h6});
    foreach (regs[i]) rdc("readback", regs[i], {i[3:0], 4'h6});
    foreach (regs[i]) wr(regs[i], 8'h00);
    tk;
    cyc(20);
    $display("test registers done");
    wr(`CRP_OFS_RECORD_CTRL, 8'h23);
    wr(`CRP_OFS_RECORD_LVOL, 8'h11);
    wr(`CRP_OFS_RECORD_RVOL, 8'hee);
    wr(`CRP_OFS_PLAY_CTRL, 8'h07);
    wr(`CRP_OFS_PLAY_LVOL, 8'h33);
    wr(`CRP_OFS_PLAY_RVOL, 8'hcc);
    cyc(1);
    chk("hpf before tick", rec_hpf_en_out, 0);
    chk("atten before tick", play_left_atten_out, 0);
    tk;
    chk("hpf", rec_hpf_en_out, 1);
    chk("rec osr", rec_osr128_out, 1);
    chk("analog src", rec_analog_en_out, 1);
    chk("rec left atten", rec_left_atten_out, 8'h11);
    chk("rec right atten", rec_right_atten_out, 8'hee);
    chk("play en", play_en_out, 1);
    chk("play osr", play_osr128_out, 1);
    chk("deemph", play_deemph_en_out, 1);
    chk("play left atten", play_left_atten_out, 8'h33);
    chk("play right atten", play_right_atten_out, 8'hcc);
    chk("line left", line_left_dac_out, 1);
    chk("line right", line_right_dac_out, 1);
    wr(`CRP_OFS_RECORD_CTRL, 8'h02);
    wr(`CRP_OFS_PLAY_CTRL, 8'h02);
    tk;
    chk("hpf off", rec_hpf_en_out, 0);
    chk("rec osr 64", rec_osr128_out, 0);
    chk("deemph off", play_deemph_en_out, 0);
    chk("play osr 64", play_osr128_out, 0);
    $display("test path settings done");
    @(posedge mclk_in);
    stall <= 1'b1;
    t0 = ticks;
    repeat (3) tk;
    chk("word waiting", rec_valid_out, 1);
    @(posedge mclk_in);
    stall <= 1'b0;
    got = 0;
    repeat (8) begin
      #1;
      if (rec_valid_out === 1'b1 && rec_ready_in === 1'b1) begin
        chk("rec left word", rec_left_out, 24'h100000 + t0 + got);
        chk("rec right word", rec_right_out, 24'h200000 + t0 + got);
        got++;
      end
      @(posedge mclk_in);
    end
    chk("words kept", got, 2);
    $display("test record buffer done");
    wr(`CRP_OFS_CLOCK_SETUP, 8'h03);
    wr(`CRP_OFS_PDM_TONE, 8'h01);
    tk;
    chk("analog off under pdm", rec_analog_en_out, 0);
    chk("pdm bits", pdm_bits_out, 1);
    rdc("pdm source", `CRP_OFS_STATUS, 8'h02);
    m0 = mic_clock_out;
    for (k = 0; mic_clock_out === m0 && k < 50; k++) @(posedge mclk_in);
    m0 = mic_clock_out;
    for (k = 0; mic_clock_out === m0 && k < 50; k++) @(posedge mclk_in);
    chk("mic clock half period", k, 4);
    wr(`CRP_OFS_PDM_TONE, 8'h00);
    tk;
    cyc(10);
    chk("mic clock idle", mic_clock_out, 0);
    chk("pdm bits idle", pdm_bits_out, 0);
    chk("analog back", rec_analog_en_out, 1);
    $display("test pdm done");
    wr(`CRP_OFS_MONO_MIX, 8'h07);
    tk;
    chk("mono left", mono_left_out, 1);
    chk("mono right", mono_right_out, 1);
    chk("mono tone off", mono_tone_out, 0);
    chk("line tone off", line_tone_out, 0);
    wr(`CRP_OFS_BIAS_TONE_EN, 8'h01);
    wr(`CRP_OFS_PDM_TONE, 8'hf8);
    tk;
    chk("mono tone", mono_tone_out, 1);
    chk("line tone", line_tone_out, 1);
    chk("tone gain", tone_gain_out, 5'h1f);
    chk("tone unmuted", tone_mute_out, 0);
    wr(`CRP_OFS_PDM_TONE, 8'hfc);
    tk;
    chk("tone muted", tone_mute_out, 1);
    $display("test mixers done");
    for (int g = 0; g < 4; g++) begin
      wr(`CRP_OFS_SPEAKER, {4'h0, g[1:0], 2'b10});
      tk;
      chk("spk gain", spk_gain_out, g[1:0]);
      chk("spk powered down", spk_precharge_out, 0);
    end
    wr(`CRP_OFS_SPEAKER, 8'h01);
    cyc(10);
    chk("precharge", spk_precharge_out, 1);
    chk("gate", spk_gate_out, 1);
    cyc(7);
    chk("mute held", spk_mute_release_out, 0);
    cyc(13);
    chk("mute released", spk_mute_release_out, 1);
    rdc("speaker on", `CRP_OFS_STATUS, 8'h0d);
    wr(`CRP_OFS_SPEAKER, 8'h00);
    cyc(2);
    chk("mute first", spk_mute_release_out, 0);
    chk("gate kept", spk_gate_out, 1);
    cyc(5);
    chk("gate undone", spk_gate_out, 0);
    chk("precharge kept", spk_precharge_out, 1);
    cyc(6);
    chk("precharge undone", spk_precharge_out, 0);
    wr(`CRP_OFS_SPEAKER, 8'h03);
    cyc(35);
    chk("muted on", spk_precharge_out, 1);
    chk("mute stays", spk_mute_release_out, 0);
    $display("test speaker done");
    test_done;
  end
endmodule // test_crp_path_ctrl
